// ### verilog/mcdma_top.sv
// six-channel triggered transfer engine with shared read and write ports
// Function
// [RL1] any address in sfr or ram space may be source or destination
// [RL2] ram access outside upper/lower limits aborts and flags the channel
// [RL3] per-channel size bit selects byte or word transfers
// [RL4] size bit clear means word, so reset default is word width
// [RL5] byte transfers pick the byte lane from the pointer lsb
// [RL6] each channel picks one of the trigger sources by select field
// [RL7] trigger choice is independent of programmed addresses
// [RL8] one-shot mode does one transaction per trigger
// [RL9] continuous mode runs back-to-back transactions until the counter ends
// [RL10] repeated one-shot does one transaction per trigger until disabled
// [RL11] repeated continuous runs a full series per trigger until disabled
// [RL12] reload option restores pointers and count; repeated modes always reload
// [RL13] pointers fixed or block, block pointers increment or decrement by size
// [RL14] indirect mode adds the peripheral offset to the base pointer
// [RL15] round-robin: lowest wins first, then later channels take turns
// [RL16] fixed: lowest requesting channel always wins
// [RL17] two power-down groups: channels 0-3 and 4-5
// [RL18] software enables, configures, then enables channel and trigger
// [RL19] software loads counter with triggers or elements per transfer
// [RL20] module registers plus five per-channel registers are provided
// [RL21] clearing controller enable stops all channels and transfers
// [RL22] priority select one means round-robin, zero means fixed
// [RL23] transfer mode codes 00 one-shot 01 rep one-shot 10 cont 11 rep cont
// [RL24] address mode codes 00 fixed 01 inc 10 dec 11 indirect
// [RL25] counter decrements per transaction, done flag when it reaches zero
`timescale 1ns/1ps
`default_nettype none
module mcdma_top
    import mcdma_pkg::*;
#(
    parameter int NUM_CH = NCH
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic controllerEnable,
    input wire logic prioritySchemeSelect,
    input wire logic lowGroupPowerDown,
    input wire logic highGroupPowerDown,
    input wire logic [AW-1:0] upperAddressLimit,
    input wire logic [AW-1:0] lowerAddressLimit,
    input wire logic [NUM_CH-1:0] channelEnable,
    input wire logic [NUM_CH-1:0] chanSizeByte,
    input wire logic [NUM_CH-1:0] chanReload,
    input wire logic [NUM_CH-1:0][1:0] transferModeSelect,
    input wire logic [NUM_CH-1:0][1:0] sourceAddrMode,
    input wire logic [NUM_CH-1:0][1:0] destAddrMode,
    input wire logic [NUM_CH-1:0][SELW-1:0] triggerSelect,
    input wire logic [NUM_CH-1:0] swRequest,
    input wire logic [NUM_CH-1:0] chanLoad,
    input wire logic [AW-1:0] loadSource,
    input wire logic [AW-1:0] loadDest,
    input wire logic [AW-1:0] loadCount,
    input wire logic [NUM_CH-1:0] flagClear,
    input wire logic [NTRIG-1:0] triggerSources,
    input wire logic [OFFW-1:0] piaOffset,
    output logic [NUM_CH-1:0][AW-1:0] sourcePointer,
    output logic [NUM_CH-1:0][AW-1:0] destinationPointer,
    output logic [NUM_CH-1:0][AW-1:0] transactionCounter,
    output logic [NUM_CH-1:0] doneFlag,
    output logic [NUM_CH-1:0] highFlag,
    output logic [NUM_CH-1:0] lowFlag,
    output logic [NUM_CH-1:0] overrunFlag,
    output logic [DW-1:0] holdingBuffer,
    output logic memRdReq,
    output logic [AW-1:0] memRdAddr,
    input wire logic memRdAck,
    input wire logic [DW-1:0] memRdData,
    output logic memWrReq,
    output logic [AW-1:0] memWrAddr,
    output logic [1:0] memWrBe,
    output logic [DW-1:0] memWrData,
    input wire logic memWrAck
);
    mcdma_rd_state_t rdState_r;
    logic [CHW-1:0] curCh_r;
    logic [CHW-1:0] lastGrant_r;
    logic [AW-1:0] srcPtr_r [NUM_CH];
    logic [AW-1:0] dstPtr_r [NUM_CH];
    logic [AW-1:0] cnt_r [NUM_CH];
    logic [AW-1:0] dstEff_r;
    logic [1:0] dstBe_r;
    logic [DW-1:0] pushData_r;
    logic [NUM_CH-1:0] chanReq;
    logic [NUM_CH-1:0] powerOff;
    logic grantValid;
    logic [CHW-1:0] grantCh;
    logic [AW-1:0] srcEff;
    logic [AW-1:0] dstEff;
    logic srcHigh;
    logic srcLow;
    logic dstHigh;
    logic dstLow;
    logic abortFire;
    logic pushFire;
    logic completeNow;
    logic reloadNow;
    logic fifoInReady;
    logic fifoOutValid;
    logic fifoOutReady;
    logic [FIFO_W-1:0] fifoOut;
    logic [DW-1:0] byteSel;
    logic [AW-1:0] stepCur;
    logic [AW-1:0] srcNxt;
    logic [AW-1:0] dstNxt;

    function automatic logic [AW-1:0] eff_addr(input logic [AW-1:0] ptr, input logic [1:0] md,
                                               input logic isByte);
        logic [AW-1:0] a;
        a = (md == AM_PIA) ? ptr + {4'h0, piaOffset} : ptr;
        return isByte ? a : {a[AW-1:1], 1'b0};
    endfunction

    function automatic logic [AW-1:0] step_ptr(input logic [AW-1:0] ptr, input logic [1:0] md,
                                               input logic [AW-1:0] st);
        case (md)
            AM_INC: step_ptr = ptr + st; // RL24
            AM_DEC: step_ptr = ptr - st;
            default: step_ptr = ptr;
        endcase
    endfunction

    // groups share one disable, individual channels cannot be gated alone
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            powerOff[i] = (i <= int'(LOW_GROUP_LAST)) ? lowGroupPowerDown : highGroupPowerDown; // RL17
        end
    end

    // round-robin searches from the channel after the last winner
    always_comb begin
        int idx;
        grantValid = 1'b0;
        grantCh = '0;
        idx = 0;
        if (prioritySchemeSelect) begin // RL22
            for (int i = 1; i <= NUM_CH; i++) begin
                idx = (int'(lastGrant_r) + i) % NUM_CH;
                if (!grantValid && chanReq[idx]) begin // RL15
                    grantValid = 1'b1;
                    grantCh = CHW'(idx);
                end
            end
        end else begin
            for (int i = NUM_CH - 1; i >= 0; i--) begin
                if (chanReq[i]) begin // RL16
                    grantValid = 1'b1;
                    grantCh = CHW'(i);
                end
            end
        end
    end

    // limits only guard space above the sfr region
    assign srcEff = eff_addr(srcPtr_r[grantCh], sourceAddrMode[grantCh], chanSizeByte[grantCh]); // RL14
    assign dstEff = eff_addr(dstPtr_r[grantCh], destAddrMode[grantCh], chanSizeByte[grantCh]); // RL1
    assign srcHigh = (srcEff >= RAM_BASE) && (srcEff > upperAddressLimit); // RL2
    assign srcLow = (srcEff >= RAM_BASE) && (srcEff < lowerAddressLimit);
    assign dstHigh = (dstEff >= RAM_BASE) && (dstEff > upperAddressLimit);
    assign dstLow = (dstEff >= RAM_BASE) && (dstEff < lowerAddressLimit);
    assign abortFire = (rdState_r == RD_IDLE) && grantValid &&
                       (srcHigh || srcLow || dstHigh || dstLow); // RL2
    assign pushFire = (rdState_r == RD_PUSH) && fifoInReady;
    assign completeNow = pushFire && (cnt_r[curCh_r] <= 16'h0001); // RL25
    assign reloadNow = chanReload[curCh_r] || transferModeSelect[curCh_r][TR_REPEAT_BIT]; // RL12
    assign stepCur = (chanSizeByte[curCh_r] == SIZE_WORD) ? STEP_WORD : STEP_BYTE; // RL4
    assign srcNxt = step_ptr(srcPtr_r[curCh_r], sourceAddrMode[curCh_r], stepCur); // RL13
    assign dstNxt = step_ptr(dstPtr_r[curCh_r], destAddrMode[curCh_r], stepCur); // RL13
    assign byteSel = memRdAddr[0] ? {memRdData[15:8], memRdData[15:8]}
                                  : {memRdData[7:0], memRdData[7:0]}; // RL5

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdState_r <= RD_IDLE;
            curCh_r <= '0;
            lastGrant_r <= LAST_CH;
            memRdReq <= 1'b0;
            memRdAddr <= '0;
            dstEff_r <= '0;
            dstBe_r <= BE_WORD;
            pushData_r <= '0;
        end else if (!controllerEnable) begin // RL21
            rdState_r <= RD_IDLE;
            memRdReq <= 1'b0;
        end else begin
            case (rdState_r)
                RD_IDLE: begin
                    if (grantValid && !abortFire) begin
                        rdState_r <= RD_READ;
                        curCh_r <= grantCh;
                        lastGrant_r <= grantCh;
                        memRdReq <= 1'b1;
                        memRdAddr <= srcEff;
                        dstEff_r <= dstEff;
                        dstBe_r <= !chanSizeByte[grantCh] ? BE_WORD
                                 : (dstEff[0] ? BE_HIGH : BE_LOW); // RL5
                    end else if (abortFire) begin
                        lastGrant_r <= grantCh;
                    end
                end
                RD_READ: begin
                    if (memRdAck) begin
                        memRdReq <= 1'b0;
                        pushData_r <= chanSizeByte[curCh_r] ? byteSel : memRdData; // RL3
                        rdState_r <= RD_PUSH;
                    end
                end
                RD_PUSH: begin
                    if (fifoInReady) begin
                        rdState_r <= RD_IDLE;
                    end
                end
                default: rdState_r <= RD_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            holdingBuffer <= '0;
        end else if (pushFire) begin
            holdingBuffer <= pushData_r; // RL20
        end
    end

    // the write side may stall, so reads run ahead until the buffer is full
    mcdma_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .flush(!controllerEnable),
        .inValid(rdState_r == RD_PUSH),
        .inReady(fifoInReady),
        .inData({dstEff_r, dstBe_r, pushData_r}),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOut)
    );

    assign fifoOutReady = controllerEnable && (!memWrReq || memWrAck);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            memWrReq <= 1'b0;
            memWrAddr <= '0;
            memWrBe <= BE_WORD;
            memWrData <= '0;
        end else if (!controllerEnable) begin // RL21
            memWrReq <= 1'b0;
        end else if (fifoOutReady) begin
            memWrReq <= fifoOutValid;
            if (fifoOutValid) begin
                memWrAddr <= fifoOut[FIFO_W-1 -: AW];
                memWrBe <= fifoOut[DW +: 2];
                memWrData <= fifoOut[DW-1:0];
            end
        end
    end

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        logic pend_r;
        logic run_r;
        logic halt_r;
        logic [AW-1:0] saveSrc_r;
        logic [AW-1:0] saveDst_r;
        logic [AW-1:0] saveCnt_r;
        logic trig;
        logic mine;
        logic live;

        assign live = controllerEnable && channelEnable[c] && !powerOff[c];
        assign trig = live && (triggerSources[triggerSelect[c]] || swRequest[c]); // RL6 RL7
        assign mine = (curCh_r == CHW'(c));
        assign chanReq[c] = live && !halt_r && (pend_r || run_r) &&
                            !(rdState_r != RD_IDLE && mine);
        assign sourcePointer[c] = srcPtr_r[c];
        assign destinationPointer[c] = dstPtr_r[c];
        assign transactionCounter[c] = cnt_r[c];

        // a trigger landing in the same cycle as the consuming transaction keeps the request
        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                pend_r <= 1'b0;
                run_r <= 1'b0;
            end else if (!live) begin // RL21
                pend_r <= 1'b0;
                run_r <= 1'b0;
            end else begin
                if (pushFire && mine) begin
                    pend_r <= 1'b0; // RL8 RL10
                end
                if ((completeNow || (pushFire && halt_r)) && mine) begin
                    run_r <= 1'b0; // RL9 RL11
                end
                if (abortFire && grantCh == CHW'(c)) begin
                    pend_r <= 1'b0;
                    run_r <= 1'b0;
                end
                if (trig && !transferModeSelect[c][TR_CONT_BIT]) begin
                    pend_r <= 1'b1; // RL8 RL10
                end
                if (trig && transferModeSelect[c][TR_CONT_BIT]) begin
                    run_r <= 1'b1; // RL9 RL11 RL23
                end
            end
        end

        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                halt_r <= 1'b0;
            end else if (chanLoad[c] || !channelEnable[c]) begin
                halt_r <= 1'b0;
            end else if (completeNow && mine && !reloadNow) begin
                halt_r <= 1'b1; // RL12
            end
        end

        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                srcPtr_r[c] <= '0;
                dstPtr_r[c] <= '0;
                cnt_r[c] <= '0;
                saveSrc_r <= '0;
                saveDst_r <= '0;
                saveCnt_r <= '0;
            end else if (chanLoad[c]) begin
                srcPtr_r[c] <= loadSource;
                dstPtr_r[c] <= loadDest;
                cnt_r[c] <= loadCount;
                saveSrc_r <= loadSource;
                saveDst_r <= loadDest;
                saveCnt_r <= loadCount;
            end else if (pushFire && mine) begin
                if (completeNow && reloadNow) begin // RL12
                    srcPtr_r[c] <= saveSrc_r;
                    dstPtr_r[c] <= saveDst_r;
                    cnt_r[c] <= saveCnt_r;
                end else begin
                    srcPtr_r[c] <= srcNxt;
                    dstPtr_r[c] <= dstNxt;
                    cnt_r[c] <= (cnt_r[c] == '0) ? '0 : cnt_r[c] - 1'b1; // RL25
                end
            end
        end

        // hardware set wins over a clear in the same cycle
        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                doneFlag[c] <= 1'b0;
                highFlag[c] <= 1'b0;
                lowFlag[c] <= 1'b0;
                overrunFlag[c] <= 1'b0;
            end else begin
                doneFlag[c] <= (completeNow && mine) || (doneFlag[c] && !flagClear[c]); // RL25
                highFlag[c] <= (abortFire && grantCh == CHW'(c) && (srcHigh || dstHigh)) ||
                               (highFlag[c] && !flagClear[c]); // RL2
                lowFlag[c] <= (abortFire && grantCh == CHW'(c) && (srcLow || dstLow)) ||
                              (lowFlag[c] && !flagClear[c]); // RL2
                overrunFlag[c] <= (trig && (pend_r || run_r)) || (overrunFlag[c] && !flagClear[c]);
            end
        end
    end

    fixed_prio_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL16
        (rdState_r == RD_IDLE && grantValid && !prioritySchemeSelect)
        |-> ((chanReq & ((NUM_CH'(1) << grantCh) - 1'b1)) == '0))
        else $error("fixed priority did not pick lowest channel");
    rr_rotate_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL15
        (rdState_r == RD_IDLE && grantValid && prioritySchemeSelect && chanReq[lastGrant_r]
         && $countones(chanReq) > 1) |-> (grantCh != lastGrant_r))
        else $error("round robin repeated the last winner");
    limit_abort_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL2
        abortFire |=> (rdState_r == RD_IDLE && !memRdReq
                       && (highFlag[$past(grantCh)] || lowFlag[$past(grantCh)])))
        else $error("out of range access was not aborted and flagged");
    rd_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (memRdReq && !memRdAck && controllerEnable) |=> (memRdReq && $stable(memRdAddr)))
        else $error("read request dropped before acknowledge");
    wr_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (memWrReq && !memWrAck && controllerEnable) |=> (memWrReq && $stable(memWrAddr)))
        else $error("write request dropped before acknowledge");
    enable_stop_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL21
        !controllerEnable |=> (rdState_r == RD_IDLE && !memRdReq && !memWrReq))
        else $error("disabled controller kept transferring");
    count_step_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL25
        (pushFire && !completeNow && !chanLoad[curCh_r])
        |=> (cnt_r[$past(curCh_r)] == $past(cnt_r[curCh_r]) - 16'h0001))
        else $error("counter did not step by one");
    done_set_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL25
        completeNow |=> doneFlag[$past(curCh_r)])
        else $error("completion flag not raised");
    group_off_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL17
        (lowGroupPowerDown && rdState_r == RD_IDLE && grantValid) |-> (grantCh > LOW_GROUP_LAST))
        else $error("powered-down group granted");
    byte_lane_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL5
        (pushFire && chanSizeByte[curCh_r]) |-> (dstBe_r == (dstEff_r[0] ? BE_HIGH : BE_LOW)))
        else $error("byte lane does not follow destination lsb");
endmodule
`default_nettype wire

// ### verilog/mcdma_pkg.sv
// shared constants for the multi-channel transfer engine
package mcdma_pkg;
    localparam int NCH = 6;
    localparam int AW = 16;
    localparam int DW = 16;
    localparam int OFFW = 12;
    localparam int CHW = 3;
    localparam int SELW = 6;
    localparam int NTRIG = 64;
    // data space split
    localparam logic [15:0] SFR_TOP = 16'h07ff;
    localparam logic [15:0] RAM_BASE = 16'h0800;
    // transfer mode field
    localparam logic [1:0] TR_ONESHOT = 2'h0;
    localparam logic [1:0] TR_REP_ONESHOT = 2'h1;
    localparam logic [1:0] TR_CONT = 2'h2;
    localparam logic [1:0] TR_REP_CONT = 2'h3;
    localparam int TR_REPEAT_BIT = 0;
    localparam int TR_CONT_BIT = 1;
    // address mode field
    localparam logic [1:0] AM_FIXED = 2'h0;
    localparam logic [1:0] AM_INC = 2'h1;
    localparam logic [1:0] AM_DEC = 2'h2;
    localparam logic [1:0] AM_PIA = 2'h3;
    // size bit: 0 word, 1 byte
    localparam logic SIZE_WORD = 1'b0;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [1:0] BE_LOW = 2'h1;
    localparam logic [1:0] BE_HIGH = 2'h2;
    localparam logic [1:0] BE_WORD = 2'h3;
    // fifo entry: destination address, byte enables, data
    localparam int FIFO_W = AW + 2 + DW;
    localparam int FIFO_DEPTH = 4;
    localparam logic [CHW-1:0] LOW_GROUP_LAST = 3'h3;
    localparam logic [CHW-1:0] LAST_CH = 3'h5;
    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_READ = 2'b01,
        RD_PUSH = 2'b11
    } mcdma_rd_state_t;
endpackage

// ### verilog/mcdma_fifo.sv
// holding buffer between read and write sides
`timescale 1ns/1ps
`default_nettype none
module mcdma_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 4
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic flush,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0] wrPtr_r;
    logic [PW:0] rdPtr_r;
    logic full;
    logic empty;

    assign full = (wrPtr_r[PW] != rdPtr_r[PW]) && (wrPtr_r[PW-1:0] == rdPtr_r[PW-1:0]);
    assign empty = (wrPtr_r == rdPtr_r);
    assign inReady = !full;
    assign outValid = !empty;
    assign outData = mem[rdPtr_r[PW-1:0]];

    always_ff @(posedge sys_clk) begin
        if (inValid && !full) begin
            mem[wrPtr_r[PW-1:0]] <= inData;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end else if (flush) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end else begin
            if (inValid && !full) begin
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (outReady && !empty) begin
                rdPtr_r <= rdPtr_r + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### dv/mcdma_mem_model.sv
// data space model answering the engine's read and write ports
`timescale 1ns/1ps
`default_nettype none
module mcdma_mem_model
    import mcdma_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [3:0] latency,
    input wire logic memRdReq,
    input wire logic [AW-1:0] memRdAddr,
    output logic memRdAck,
    output logic [DW-1:0] memRdData,
    input wire logic memWrReq,
    input wire logic [AW-1:0] memWrAddr,
    input wire logic [1:0] memWrBe,
    input wire logic [DW-1:0] memWrData,
    output logic memWrAck
);
    logic [DW-1:0] mem [0:32767];
    logic [3:0] rdWait = 4'h0;
    logic [3:0] wrWait = 4'h0;
    initial begin
        memRdAck = 1'b0;
        memWrAck = 1'b0;
        memRdData = 16'h0000;
    end
    // sfr and ram space share one array
    always @(posedge sys_clk) begin
        memRdAck <= 1'b0;
        // idle bus toggles so a stale word is never mistaken for data
        memRdData <= ~memRdData;
        rdWait <= (memRdReq && !memRdAck) ? rdWait + 4'h1 : 4'h0;
        if (memRdReq && !memRdAck && rdWait >= latency) begin
            memRdAck <= 1'b1;
            memRdData <= mem[memRdAddr[15:1]];
        end
    end
    always @(posedge sys_clk) begin
        memWrAck <= 1'b0;
        wrWait <= (memWrReq && !memWrAck) ? wrWait + 4'h1 : 4'h0;
        if (memWrReq && !memWrAck && wrWait >= latency) begin
            memWrAck <= 1'b1;
            if (memWrBe[0]) mem[memWrAddr[15:1]][7:0] <= memWrData[7:0];
            if (memWrBe[1]) mem[memWrAddr[15:1]][15:8] <= memWrData[15:8];
        end
    end
endmodule
`default_nettype wire

// ### dv/mcdma_top_bench.sv
// self-checking bench: transfers, byte lanes, limits, arbitration, disables
`timescale 1ns/1ps
`default_nettype none
module mcdma_top_bench
    import mcdma_pkg::*;
;
    logic sys_clk = 1'b0, resetn = 1'b0, controllerEnable = 1'b1, prioritySchemeSelect = 1'b0;
    logic lowGroupPowerDown = 1'b0, highGroupPowerDown = 1'b0;
    logic [AW-1:0] upperAddressLimit = 16'hffff, lowerAddressLimit = 16'h0800;
    logic [AW-1:0] loadSource = 16'h0000, loadDest = 16'h0000, loadCount = 16'h0000;
    logic [NCH-1:0] channelEnable = '0, chanSizeByte = '0, chanReload = '0, swRequest = '0;
    logic [NCH-1:0] chanLoad = '0, flagClear = '0, doneFlag, highFlag, lowFlag, overrunFlag;
    logic [NCH-1:0][1:0] transferModeSelect = '0, sourceAddrMode = '0, destAddrMode = '0;
    logic [NCH-1:0][SELW-1:0] triggerSelect = '0;
    logic [NTRIG-1:0] triggerSources = '0;
    logic [OFFW-1:0] piaOffset = 12'h000;
    logic [NCH-1:0][AW-1:0] sourcePointer, destinationPointer, transactionCounter;
    logic [DW-1:0] holdingBuffer, memRdData, memWrData;
    logic [AW-1:0] memRdAddr, memWrAddr;
    logic [1:0] memWrBe;
    logic [3:0] latency = 4'h0;
    logic memRdReq, memRdAck, memWrReq, memWrAck;
    logic [15:0] rdLog [$];
    int errors = 0;
    int checksDone = 0;
    int cycles = 0;

    mcdma_top i_mcdma_top (.*);
    mcdma_mem_model i_mcdma_mem_model (.*);

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (memRdReq === 1'b1 && memRdAck === 1'b1) rdLog.push_back(memRdAddr);
        cycles++;
        if (cycles == 2000) begin
            errors++;
            print_verdict();
        end
    end

    function automatic logic [15:0] pat(input int i);
        return 16'(i) ^ 16'hc35a;
    endfunction
    function automatic logic [15:0] word(input int i);
        return i_mcdma_mem_model.mem[i];
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        checksDone++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_flag(input logic got, input logic exp);
        check_word({15'h0000, got}, {15'h0000, exp});
    endtask
    // channel is held off while loaded, as software must
    task automatic setup(input int ch, input logic [1:0] tm, input logic [15:0] s, d, c);
        channelEnable[ch] = 1'b0;
        transferModeSelect[ch] = tm;
        sourceAddrMode[ch] = AM_INC;
        destAddrMode[ch] = AM_INC;
        triggerSelect[ch] = SELW'(ch + 5);
        loadSource = s;
        loadDest = d;
        loadCount = c;
        chanLoad[ch] = 1'b1;
        tick(1);
        chanLoad = '0;
        channelEnable[ch] = 1'b1;
        tick(1);
    endtask
    task automatic fire(input logic [NTRIG-1:0] m, input logic [NCH-1:0] sw, input int n);
        rdLog.delete();
        triggerSources = m;
        swRequest = sw;
        tick(1);
        triggerSources = '0;
        swRequest = '0;
        tick(n);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checksDone, errors);
        if (errors == 0 && checksDone > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        for (int i = 0; i < 32768; i++) begin
            i_mcdma_mem_model.mem[i] = pat(i);
        end
        tick(10);
        resetn = 1'b1;
        check_word(sourcePointer[0], 16'h0000);
        check_word({14'h0000, memWrBe}, 16'h0003);
        setup(0, TR_ONESHOT, 16'h0100, 16'h0a00, 16'h0002);
        fire(64'h20, '0, 30);
        check_word(16'(rdLog.size()), 16'h0001);
        check_word(word(16'h0500), pat(16'h0080));
        check_word(transactionCounter[0], 16'h0001);
        check_word(destinationPointer[0], 16'h0a02);
        check_flag(doneFlag[0], 1'b0);
        latency = 4'h3;
        fire(64'h20, '0, 40);
        check_word(word(16'h0501), pat(16'h0081));
        check_flag(doneFlag[0], 1'b1);
        chanSizeByte[1] = 1'b1;
        setup(1, TR_CONT, 16'h0201, 16'h0b01, 16'h0002);
        fire('0, 6'h02, 60);
        check_word(16'(rdLog.size()), 16'h0002);
        check_word(word(16'h0580), (pat(16'h0100) & 16'hff00) | (pat(16'h0580) & 16'h00ff));
        check_word(word(16'h0581), (pat(16'h0581) & 16'hff00) | (pat(16'h0101) & 16'h00ff));
        upperAddressLimit = 16'h0c00;
        lowerAddressLimit = 16'h0900;
        setup(2, TR_ONESHOT, 16'h0100, 16'h0d00, 16'h0001);
        setup(3, TR_ONESHOT, 16'h0100, 16'h0880, 16'h0001);
        fire(64'h180, '0, 30);
        check_flag(highFlag[2], 1'b1);
        check_flag(lowFlag[3], 1'b1);
        check_word(16'(rdLog.size()), 16'h0000);
        check_word(word(16'h0440), pat(16'h0440));
        upperAddressLimit = 16'hffff;
        lowerAddressLimit = 16'h0800;
        // a two-word series on ch4 collides with ch5 twice
        for (int p = 0; p < 2; p++) begin
            prioritySchemeSelect = p[0];
            setup(4, TR_CONT, 16'h0300, 16'h0c00, 16'h0002);
            setup(5, TR_ONESHOT, 16'h0310, 16'h0c10, 16'h0001);
            fire(64'h600, '0, 60);
            check_word(rdLog[0], 16'h0300);
            check_word(rdLog[1], p[0] ? 16'h0310 : 16'h0302);
        end
        setup(2, TR_REP_CONT, 16'h0104, 16'h0e00, 16'h0002);
        sourceAddrMode[2] = AM_DEC;
        fire(64'h80, '0, 40);
        check_word(sourcePointer[2], 16'h0104);
        check_word(word(16'h0701), pat(16'h0081));
        triggerSources = 64'h80;
        tick(1);
        fire(64'h80, '0, 40);
        check_word(16'(rdLog.size()), 16'h0002);
        check_flag(overrunFlag[2], 1'b1);
        check_word(holdingBuffer, pat(16'h0081));
        setup(0, TR_ONESHOT, 16'h0100, 16'h0a00, 16'h0002);
        setup(4, TR_ONESHOT, 16'h0300, 16'h0c00, 16'h0002);
        for (int k = 0; k < 4; k++) begin
            lowGroupPowerDown = (k == 0);
            highGroupPowerDown = (k == 1);
            controllerEnable = (k != 2);
            fire((k == 1) ? 64'h200 : 64'h20, '0, 30);
            check_word(16'(rdLog.size()), (k == 3) ? 16'h0001 : 16'h0000);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
